// >>> core/conv_prot_pkg.sv
package conv_prot_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;  // system clock rate
  localparam int TICK_US         = 1;           // timer resolution in microseconds
  localparam int TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int QUIET_TIME_S    = 65;          // occurrence counter quiet time
  localparam int QUIET_TICKS_DEF = QUIET_TIME_S * 1_000_000 / TICK_US;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_OPP_LVL  = 8'h04;
  localparam logic [7:0] OFS_OCP_TIME = 8'h08;
  localparam logic [7:0] OFS_START    = 8'h0c;
  localparam logic [7:0] OFS_OPP1     = 8'h10;
  localparam logic [7:0] OFS_OPP2     = 8'h14;
  localparam logic [7:0] OFS_RESTART  = 8'h18;
  localparam logic [7:0] OFS_FLR      = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_FAULT    = 8'h24;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OCP_EN = 0;   // overcurrent protection state enable
  localparam int CTRL_OPP1_EN = 1;  // first overpower level enable
  localparam int CTRL_OPP2_EN = 2;  // second overpower level enable
  localparam int CTRL_OVPS_EN = 3;  // boost overvoltage stop warning enable
  localparam int CTRL_BOS_EN = 4;   // brownout stop warning enable
  localparam int CTRL_POL_LSB = 8;  // response policy, two bits
  localparam int CTRL_LIM_LSB = 12; // occurrence limit, four bits

  // fault record bit positions
  localparam int FLT_OCP = 0;
  localparam int FLT_START = 1;
  localparam int FLT_OPP1 = 2;
  localparam int FLT_OPP2 = 3;
  localparam int FLT_OVP = 4;
  localparam int FLT_UVP = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  RST_ENABLES = 5'h07;
  localparam logic [1:0]  RST_POLICY  = 2'h1;
  localparam logic [3:0]  RST_LIMIT   = 4'h3;
  localparam logic [7:0]  RST_MAX_PCT = 8'haa;    // 170 percent
  localparam logic [7:0]  RST_OFF1    = 8'h14;    // 20 percent below max
  localparam logic [7:0]  RST_OFF2    = 8'h32;    // 50 percent below max
  localparam logic [23:0] RST_TIME    = 24'h0003e8;
  localparam logic [7:0]  FB_HIGH     = 8'hff;
  localparam logic [7:0]  FB_LOW      = 8'h00;

  // response policies
  localparam logic [1:0] POL_LATCH = 2'h0;
  localparam logic [1:0] POL_SAFE  = 2'h1;
  localparam logic [1:0] POL_LSR   = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_BOOST   = 5'h01,  // boost stage alone
    ST_RES     = 5'h02,  // both stages starting
    ST_OPERATE = 5'h04,  // in regulation, power good
    ST_WAIT    = 5'h08,  // safe restart delay
    ST_LATCHED = 5'h10   // latched off
  } state_type;

  // analog comparator and A/D results
  typedef struct packed {
    logic       ocp_above;     // primary current sense over threshold
    logic [7:0] power_pct;     // output power, percent of rated
    logic       boost_start;   // boost output above resonant start level
    logic       boost_detect;  // boost sense above detect level
    logic       output_reg;    // resonant output in regulation
    logic       supply_uv;     // chip supply under undervoltage level
    logic       mains_bo;      // mains below brownout level
    logic       otp_soon;      // overtemperature stop imminent
    logic       ovp_stop;      // boost overvoltage stop imminent
    logic       bo_stop;       // brownout stop imminent
    logic       ovp;           // overvoltage protection
    logic       uvp;           // undervoltage protection
  } sense_type;

  // supervisor state, registered as one word
  typedef struct packed {
    state_type   fsm;
    logic [5:0]  tick_cnt;     // microsecond divider
    logic [23:0] ocp_cnt;      // overcurrent persistence
    logic [23:0] opp1_cnt;     // first overpower timer
    logic [23:0] opp2_cnt;     // second overpower timer
    logic [23:0] start_cnt;    // start-up timer
    logic [23:0] wait_cnt;     // safe restart delay
    logic [23:0] flr_cnt;      // brownout duration
    logic [26:0] quiet_cnt;    // time since last trigger
    logic [3:0]  occ;          // occurrence counter
    logic [7:0]  fault;        // sticky fault record
    logic [7:0]  fb;           // feedback pin level
    logic        cut_ls;       // low side cut by overcurrent this pulse
    logic        cut_hs;       // high side cut by overcurrent this pulse
    logic        gate_ls;      // low side gate drive
    logic        gate_hs;      // high side gate drive
    logic        boost;        // boost stage running
    logic        plim;         // power limit request
    logic [31:0] rd;           // read data, one cycle
    logic [4:0]  en;           // control enables
    logic [1:0]  policy;       // response policy
    logic [3:0]  limit;        // occurrence limit
    logic [7:0]  max_pct;      // maximum power, percent
    logic [7:0]  off1;         // first level offset
    logic [7:0]  off2;         // second level offset
    logic [23:0] ocp_time;     // overcurrent persistence limit
    logic [23:0] start_time;   // maximum start-up time
    logic [23:0] opp1_time;    // first level timer limit
    logic [23:0] opp2_time;    // second level timer limit
    logic [23:0] wait_time;    // safe restart delay
    logic [23:0] flr_time;     // brownout time for fast latch reset
  } regs_type;

endpackage

// >>> core/converter_protection_supervisor.sv
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

// Contract
// - overcurrent turns off active gate, switching continues
// - persistent overcurrent enters protection unless disabled
// - boost first, resonant after boost level
// - start-up timer trips if not regulated
// - start-up timeout uses overpower policy
// - cycle-by-cycle power limit at max percent
// - first level timer stops both stages
// - first level timer configurable, level disableable
// - second level own timer, disableable
// - policy latched, safe restart, or both
// - latched resumes on fast reset or supply
// - safe restart after one shared delay
// - occurrence counter latches at configured count
// - counter cleared after 65 quiet seconds
// - long brownout restarts from any protection
// - feedback high at start, low when operating
// - feedback high ahead of warned stops
// - feedback moves along a ramp
// - hard protections pull feedback high at once
// - fault record held until software clears
module converter_protection_supervisor #(
  parameter int QUIET_TICKS = conv_prot_pkg::QUIET_TICKS_DEF  // quiet time in ticks
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // register port
  input  wire logic [7:0]              addr_i,
  input  wire logic [31:0]             wr_data_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [31:0]             rd_data_o,
  // sense inputs and gate requests
  input  wire conv_prot_pkg::sense_type sense_i,
  input  wire logic                    ls_req_i,
  input  wire logic                    hs_req_i,
  // converter controls
  output logic                         low_side_gate_o,
  output logic                         high_side_gate_o,
  output logic                         boost_run_o,
  output logic                         power_limit_o,
  output logic      [7:0]              feedback_sense_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  conv_prot_pkg::regs_type s_reg;   // registered state
  conv_prot_pkg::regs_type s_next;  // next state
  // elaboration check: quiet counter width
  if (QUIET_TICKS < 1 || QUIET_TICKS > 27'h7ffffff)
  begin : g_bad_quiet
    $error("QUIET_TICKS out of range");
  end

  // persistence timer: counts ticks while cause holds, clears when it leaves
  function automatic logic [23:0] timer_step(input logic [23:0] cnt,
                                             input logic cond, input logic tick);
    timer_step = cnt;
    if (!cond)
      timer_step = '0;
    else if (tick && cnt != 24'hffffff)
      timer_step = cnt + 24'h000001;
  endfunction

  // threshold below max, clamped at zero
  function automatic logic [7:0] below_max(input logic [7:0] mx, input logic [7:0] off);
    below_max = (off > mx) ? 8'h00 : mx - off;
  endfunction

  // ----------------------------------------------------------------
  // combinational view
  // ----------------------------------------------------------------
  logic tick;
  logic run_res;
  logic ocp_active;
  logic opp1_hit;
  logic opp2_hit;
  logic ocp_trip;
  logic start_trip;
  logic opp1_trip;
  logic opp2_trip;
  logic hard_trip;
  logic any_trip;
  logic flr_fire;
  logic warn;
  logic fault_wr;
  logic [3:0] occ_inc;

  always_comb
  begin
    tick       = s_reg.tick_cnt == 6'(conv_prot_pkg::TICK_CYCLES - 1);
    run_res    = s_reg.fsm == conv_prot_pkg::ST_RES || s_reg.fsm == conv_prot_pkg::ST_OPERATE;
    ocp_active = sense_i.ocp_above || s_reg.cut_ls || s_reg.cut_hs;
    opp1_hit   = s_reg.en[conv_prot_pkg::CTRL_OPP1_EN]
                 && sense_i.power_pct >= below_max(s_reg.max_pct, s_reg.off1);
    opp2_hit   = s_reg.en[conv_prot_pkg::CTRL_OPP2_EN]
                 && sense_i.power_pct >= below_max(s_reg.max_pct, s_reg.off2);
    ocp_trip   = run_res && s_reg.en[conv_prot_pkg::CTRL_OCP_EN] && ocp_active
                 && s_reg.ocp_cnt >= s_reg.ocp_time;
    start_trip = (s_reg.fsm == conv_prot_pkg::ST_BOOST || s_reg.fsm == conv_prot_pkg::ST_RES)
                 && s_reg.start_cnt >= s_reg.start_time;
    opp1_trip  = run_res && opp1_hit && s_reg.opp1_cnt >= s_reg.opp1_time;
    opp2_trip  = run_res && opp2_hit && s_reg.opp2_cnt >= s_reg.opp2_time;
    hard_trip  = s_reg.boost && (sense_i.ovp || sense_i.uvp);
    any_trip   = hard_trip || ocp_trip || start_trip || opp1_trip || opp2_trip;
    flr_fire   = sense_i.mains_bo && s_reg.flr_cnt >= s_reg.flr_time;
    // early warning of a coming stop
    warn       = !sense_i.boost_detect || sense_i.otp_soon
                 || (opp1_hit && s_reg.opp1_cnt >= s_reg.opp1_time - (s_reg.opp1_time >> 3))
                 || (opp2_hit && s_reg.opp2_cnt >= s_reg.opp2_time - (s_reg.opp2_time >> 3))
                 || (s_reg.en[conv_prot_pkg::CTRL_OVPS_EN] && sense_i.ovp_stop)
                 || (s_reg.en[conv_prot_pkg::CTRL_BOS_EN] && sense_i.bo_stop);
    fault_wr   = wr_i && addr_i == conv_prot_pkg::OFS_FAULT;
    occ_inc    = (s_reg.occ == 4'hf) ? s_reg.occ : s_reg.occ + 4'h1;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.tick_cnt = tick ? 6'h00 : s_reg.tick_cnt + 6'h01;

    // register writes
    if (wr_i)
    begin
      case (addr_i)
        conv_prot_pkg::OFS_CTRL:
        begin
          s_next.en     = wr_data_i[4:0];
          s_next.policy = wr_data_i[conv_prot_pkg::CTRL_POL_LSB +: 2];
          s_next.limit  = wr_data_i[conv_prot_pkg::CTRL_LIM_LSB +: 4];
        end
        conv_prot_pkg::OFS_OPP_LVL:
        begin
          s_next.max_pct = wr_data_i[7:0];
          s_next.off1    = wr_data_i[15:8];
          s_next.off2    = wr_data_i[23:16];
        end
        conv_prot_pkg::OFS_OCP_TIME: s_next.ocp_time   = wr_data_i[23:0];
        conv_prot_pkg::OFS_START:    s_next.start_time = wr_data_i[23:0];
        conv_prot_pkg::OFS_OPP1:     s_next.opp1_time  = wr_data_i[23:0];
        conv_prot_pkg::OFS_OPP2:     s_next.opp2_time  = wr_data_i[23:0];
        conv_prot_pkg::OFS_RESTART:  s_next.wait_time  = wr_data_i[23:0];
        conv_prot_pkg::OFS_FLR:      s_next.flr_time   = wr_data_i[23:0];
        default: ;  // read-only and unmapped writes ignored
      endcase
    end

    // register reads, data in the next cycle only
    s_next.rd = '0;
    if (rd_i)
    begin
      case (addr_i)
        conv_prot_pkg::OFS_CTRL:     s_next.rd = {16'h0000, s_reg.limit, 2'b00,
                                                  s_reg.policy, 3'b000, s_reg.en};
        conv_prot_pkg::OFS_OPP_LVL:  s_next.rd = {8'h00, s_reg.off2, s_reg.off1, s_reg.max_pct};
        conv_prot_pkg::OFS_OCP_TIME: s_next.rd = {8'h00, s_reg.ocp_time};
        conv_prot_pkg::OFS_START:    s_next.rd = {8'h00, s_reg.start_time};
        conv_prot_pkg::OFS_OPP1:     s_next.rd = {8'h00, s_reg.opp1_time};
        conv_prot_pkg::OFS_OPP2:     s_next.rd = {8'h00, s_reg.opp2_time};
        conv_prot_pkg::OFS_RESTART:  s_next.rd = {8'h00, s_reg.wait_time};
        conv_prot_pkg::OFS_FLR:      s_next.rd = {8'h00, s_reg.flr_time};
        conv_prot_pkg::OFS_STATUS:   s_next.rd = {11'h000, s_reg.fsm, s_reg.fb, 4'h0, s_reg.occ};
        conv_prot_pkg::OFS_FAULT:    s_next.rd = {24'h000000, s_reg.fault};
        default:                     s_next.rd = '0;
      endcase
    end

    // persistence timers restart when the cause leaves
    s_next.ocp_cnt   = timer_step(s_reg.ocp_cnt, run_res && ocp_active, tick);
    s_next.opp1_cnt  = timer_step(s_reg.opp1_cnt, run_res && opp1_hit, tick);
    s_next.opp2_cnt  = timer_step(s_reg.opp2_cnt, run_res && opp2_hit, tick);
    s_next.start_cnt = timer_step(s_reg.start_cnt, s_reg.fsm == conv_prot_pkg::ST_BOOST
                                  || s_reg.fsm == conv_prot_pkg::ST_RES, tick);
    s_next.wait_cnt  = timer_step(s_reg.wait_cnt, s_reg.fsm == conv_prot_pkg::ST_WAIT, tick);
    s_next.flr_cnt   = timer_step(s_reg.flr_cnt, sense_i.mains_bo, tick);

    // quiet time clears the occurrence counter
    if (any_trip)
      s_next.quiet_cnt = '0;
    else if (tick && s_reg.quiet_cnt != 27'(QUIET_TICKS))
      s_next.quiet_cnt = s_reg.quiet_cnt + 27'h0000001;
    if (!any_trip && s_reg.quiet_cnt == 27'(QUIET_TICKS))
      s_next.occ = 4'h0;

    // sticky fault record, write one to clear, a new event wins
    if (fault_wr)
      s_next.fault = s_reg.fault & ~wr_data_i[7:0];
    if (ocp_trip)
      s_next.fault[conv_prot_pkg::FLT_OCP] = 1'b1;
    if (start_trip)
      s_next.fault[conv_prot_pkg::FLT_START] = 1'b1;
    if (opp1_trip)
      s_next.fault[conv_prot_pkg::FLT_OPP1] = 1'b1;
    if (opp2_trip)
      s_next.fault[conv_prot_pkg::FLT_OPP2] = 1'b1;
    if (s_reg.boost && sense_i.ovp)
      s_next.fault[conv_prot_pkg::FLT_OVP] = 1'b1;
    if (s_reg.boost && sense_i.uvp)
      s_next.fault[conv_prot_pkg::FLT_UVP] = 1'b1;

    // sequencing
    case (s_reg.fsm)
      // resonant stage waits for boost level
      conv_prot_pkg::ST_BOOST:
        if (sense_i.boost_start)
          s_next.fsm = conv_prot_pkg::ST_RES;
      conv_prot_pkg::ST_RES:
        if (sense_i.output_reg)
          s_next.fsm = conv_prot_pkg::ST_OPERATE;
      conv_prot_pkg::ST_OPERATE: ;
      conv_prot_pkg::ST_WAIT:
        if (s_reg.wait_cnt >= s_reg.wait_time)
          s_next.fsm = conv_prot_pkg::ST_BOOST;
      // latched until supply loss or fast reset
      conv_prot_pkg::ST_LATCHED:
        if (sense_i.supply_uv)
          s_next.fsm = conv_prot_pkg::ST_BOOST;
      default: s_next.fsm = conv_prot_pkg::ST_LATCHED;
    endcase

    // every trip follows the overpower policy
    if (any_trip)
    begin
      s_next.wait_cnt = '0;
      case (s_reg.policy)
        conv_prot_pkg::POL_LATCH: s_next.fsm = conv_prot_pkg::ST_LATCHED;
        conv_prot_pkg::POL_LSR:
        begin
          s_next.occ = occ_inc;
          s_next.fsm = (occ_inc >= s_reg.limit) ? conv_prot_pkg::ST_LATCHED
                                                : conv_prot_pkg::ST_WAIT;
        end
        default: s_next.fsm = conv_prot_pkg::ST_WAIT;
      endcase
    end

    // fast latch reset leaves any protection state
    if (flr_fire && (s_reg.fsm == conv_prot_pkg::ST_WAIT
                     || s_reg.fsm == conv_prot_pkg::ST_LATCHED))
      s_next.fsm = conv_prot_pkg::ST_BOOST;

    // cut the conducting gate for the rest of its pulse
    s_next.cut_ls  = s_reg.cut_ls ? ls_req_i : (sense_i.ocp_above && s_reg.gate_ls);
    s_next.cut_hs  = s_reg.cut_hs ? hs_req_i : (sense_i.ocp_above && s_reg.gate_hs);
    s_next.gate_ls = run_res && !any_trip && ls_req_i && !hs_req_i
                     && !sense_i.ocp_above && !s_reg.cut_ls;
    s_next.gate_hs = run_res && !any_trip && hs_req_i && !ls_req_i
                     && !sense_i.ocp_above && !s_reg.cut_hs;
    s_next.boost   = !any_trip && (s_next.fsm == conv_prot_pkg::ST_BOOST
                     || s_next.fsm == conv_prot_pkg::ST_RES
                     || s_next.fsm == conv_prot_pkg::ST_OPERATE);
    s_next.plim    = sense_i.power_pct >= s_reg.max_pct;

    // ramp toward high unless operating without warning
    if (tick)
    begin
      if (s_reg.fsm != conv_prot_pkg::ST_OPERATE || warn)
        s_next.fb = (s_reg.fb == conv_prot_pkg::FB_HIGH) ? s_reg.fb : s_reg.fb + 8'h01;
      else
        s_next.fb = (s_reg.fb == conv_prot_pkg::FB_LOW) ? s_reg.fb : s_reg.fb - 8'h01;
    end
    // hard protections step the pin high at once
    if (hard_trip || ocp_trip)
      s_next.fb = conv_prot_pkg::FB_HIGH;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg            <= '0;
      s_reg.fsm        <= conv_prot_pkg::ST_BOOST;
      s_reg.boost      <= 1'b1;
      s_reg.fb         <= conv_prot_pkg::FB_HIGH;
      s_reg.en         <= conv_prot_pkg::RST_ENABLES;
      s_reg.policy     <= conv_prot_pkg::RST_POLICY;
      s_reg.limit      <= conv_prot_pkg::RST_LIMIT;
      s_reg.max_pct    <= conv_prot_pkg::RST_MAX_PCT;
      s_reg.off1       <= conv_prot_pkg::RST_OFF1;
      s_reg.off2       <= conv_prot_pkg::RST_OFF2;
      s_reg.ocp_time   <= conv_prot_pkg::RST_TIME;
      s_reg.start_time <= conv_prot_pkg::RST_TIME;
      s_reg.opp1_time  <= conv_prot_pkg::RST_TIME;
      s_reg.opp2_time  <= conv_prot_pkg::RST_TIME;
      s_reg.wait_time  <= conv_prot_pkg::RST_TIME;
      s_reg.flr_time   <= conv_prot_pkg::RST_TIME;
    end
    else
      s_reg <= s_next;
  end

  assign rd_data_o        = s_reg.rd;
  assign low_side_gate_o  = s_reg.gate_ls;
  assign high_side_gate_o = s_reg.gate_hs;
  assign boost_run_o      = s_reg.boost;
  assign power_limit_o    = s_reg.plim;
  assign feedback_sense_o = s_reg.fb;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence trip_latched_s;
    any_trip && s_reg.policy == conv_prot_pkg::POL_LATCH && !flr_fire;
  endsequence

  sequence wait_done_s;
    s_reg.fsm == conv_prot_pkg::ST_WAIT && s_reg.wait_cnt >= s_reg.wait_time
    && !any_trip && !flr_fire;
  endsequence

  gate_cut_a: assert property (sense_i.ocp_above |=> !low_side_gate_o && !high_side_gate_o)
    else $error("gate on during overcurrent");
  ocp_trip_a: assert property (ocp_trip && !flr_fire |=> s_reg.fsm inside
    {conv_prot_pkg::ST_WAIT, conv_prot_pkg::ST_LATCHED} && s_reg.fault[conv_prot_pkg::FLT_OCP])
    else $error("overcurrent timeout missed");
  res_order_a: assert property (s_reg.fsm == conv_prot_pkg::ST_BOOST && !sense_i.boost_start
    |=> s_reg.fsm != conv_prot_pkg::ST_RES && !low_side_gate_o && !high_side_gate_o)
    else $error("resonant stage started early");
  start_to_a: assert property (start_trip |=> s_reg.fault[conv_prot_pkg::FLT_START]
    && !boost_run_o)
    else $error("start-up timeout not taken");
  latch_pol_a: assert property (trip_latched_s |=> s_reg.fsm == conv_prot_pkg::ST_LATCHED
    ##1 (s_reg.fsm == conv_prot_pkg::ST_LATCHED || $past(sense_i.supply_uv)
    || $past(flr_fire)))
    else $error("latched policy not held");
  restart_a: assert property (wait_done_s |=> s_reg.fsm == conv_prot_pkg::ST_BOOST
    ##1 boost_run_o || $past(any_trip))
    else $error("safe restart delay not honoured");
  occ_latch_a: assert property (any_trip && s_reg.policy == conv_prot_pkg::POL_LSR
    && occ_inc >= s_reg.limit && !flr_fire |=> s_reg.fsm == conv_prot_pkg::ST_LATCHED)
    else $error("occurrence limit did not latch");
  plim_a: assert property (sense_i.power_pct >= s_reg.max_pct |=> power_limit_o)
    else $error("power limit missing");
  fb_ramp_a: assert property (tick && s_reg.fsm == conv_prot_pkg::ST_OPERATE && !warn
    && !any_trip && s_reg.fb != conv_prot_pkg::FB_LOW |=> feedback_sense_o == $past(s_reg.fb) - 8'h01)
    else $error("feedback ramp step wrong");
  fb_hard_a: assert property (hard_trip |=> feedback_sense_o == conv_prot_pkg::FB_HIGH
    && !low_side_gate_o && !high_side_gate_o)
    else $error("hard protection left pin low");
  fault_hold_a: assert property (!fault_wr |=> (s_reg.fault & $past(s_reg.fault))
    == $past(s_reg.fault))
    else $error("fault record lost");

endmodule

// >>> tb/sense_model.sv
`timescale 1ns/1ps
// stand-in for the sense comparators and the half-bridge oscillator
module sense_model (
  // clock and bench controls
  input  wire logic                      clk_i,
  input  wire logic                      ocp_i,
  input  wire logic                      up_i,
  input  wire logic [7:0]                pct_i,
  // sense results and gate requests
  output conv_prot_pkg::sense_type       sense_o,
  output logic                           ls_req_o,
  output logic                           hs_req_o
);
  logic [4:0] phase_reg = 5'h00;  // oscillator phase, 20 cycles a period
  // two dead cycles between requests, so both are never high together
  always @(posedge clk_i)
    phase_reg <= (phase_reg == 5'h13) ? 5'h00 : phase_reg + 5'h01;
  assign ls_req_o = phase_reg < 5'h08;
  assign hs_req_o = phase_reg > 5'h09 && phase_reg < 5'h12;
  // supply and mains stay healthy; boost and regulation follow up_i
  always_comb
  begin
    sense_o              = '0;
    sense_o.ocp_above    = ocp_i;
    sense_o.power_pct    = pct_i;
    sense_o.boost_start  = up_i;
    sense_o.boost_detect = up_i;
    sense_o.output_reg   = up_i;
  end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, ocp = 1'b0, up = 1'b0;
  logic rd_seen = 1'b0, ls_req, hs_req, ls_gate, hs_gate, boost_run, plim;
  logic [7:0] addr_i = 8'h00, pct = 8'h00, fb;
  logic [31:0] wr_data_i = 32'h0, rd_data_o;
  logic [31:0] exp_q[$];  // expected read data, oldest first
  conv_prot_pkg::sense_type sense;
  int fail_count = 0, comparisons = 0, seed = 32'h696d4fc4;
  always #12.5 clk_i = ~clk_i;
  // power stays below rated, so no overpower level can start
  always @(posedge clk_i) pct <= 8'($unsigned($random(seed)) % 100);
  sense_model partner (.clk_i(clk_i), .ocp_i(ocp), .up_i(up), .pct_i(pct),
    .sense_o(sense), .ls_req_o(ls_req), .hs_req_o(hs_req));
  converter_protection_supervisor #(.QUIET_TICKS(200)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .sense_i(sense), .ls_req_i(ls_req), .hs_req_i(hs_req), .low_side_gate_o(ls_gate),
    .high_side_gate_o(hs_gate), .boost_run_o(boost_run), .power_limit_o(plim),
    .feedback_sense_o(fb));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one bus cycle; a read notes its expected data for the monitor
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    wr_i <= wr;
    rd_i <= !wr;
    addr_i <= a;
    wr_data_i <= d;
    if (!wr)
      exp_q.push_back(d);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk_i)
  begin
    rd_seen <= rd_i;
    if (rd_seen)
      check("read data", rd_data_o, exp_q.pop_front());
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial
  begin
    #500_000;
    fail_count++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, conv_prot_pkg::OFS_CTRL, 32'h00003107);
    bus(1'b0, conv_prot_pkg::OFS_OPP_LVL, 32'h003214aa);
    bus(1'b0, conv_prot_pkg::OFS_START, 32'h000003e8);
    bus(1'b0, 8'h30, 32'h0);
    bus(1'b1, conv_prot_pkg::OFS_CTRL, 32'h00002106);
    bus(1'b0, conv_prot_pkg::OFS_CTRL, 32'h00002106);
    $display("registers done");
    // gates stay off while only the boost runs
    repeat (40)
    begin
      @(negedge clk_i);
      check("boost first", {29'h0, boost_run, ls_gate, hs_gate}, 32'h4);
    end
    @(posedge clk_i);
    up <= 1'b1;
    repeat (100) @(posedge clk_i);
    @(negedge clk_i);
    check("fb ramp", {31'h0, fb !== 8'hff && fb !== 8'h00}, 32'h1);
    check("power limit", {31'h0, plim}, 32'h0);
    $display("start-up done");
    // overcurrent cuts the low side; the high side still switches
    @(posedge clk_i iff ls_req);
    @(negedge clk_i);
    check("low gate on", {31'h0, ls_gate}, 32'h1);
    @(posedge clk_i);
    ocp <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    ocp <= 1'b0;
    @(negedge clk_i);
    check("low gate cut", {31'h0, ls_gate}, 32'h0);
    @(posedge clk_i iff hs_req);
    @(negedge clk_i);
    check("high gate on", {31'h0, hs_gate}, 32'h1);
    bus(1'b0, conv_prot_pkg::OFS_FAULT, 32'h0);
    $display("overcurrent done");
    // timed overcurrent under the latched policy stops everything at once
    bus(1'b1, conv_prot_pkg::OFS_OCP_TIME, 32'h00000001);
    bus(1'b1, conv_prot_pkg::OFS_CTRL, 32'h00000007);
    @(posedge clk_i);
    ocp <= 1'b1;
    repeat (100) @(posedge clk_i);
    ocp <= 1'b0;
    repeat (50) @(posedge clk_i);
    @(negedge clk_i);
    check("ocp latched", {21'h0, boost_run, ls_gate, hs_gate, fb}, 32'hff);
    bus(1'b0, conv_prot_pkg::OFS_FAULT, 32'h00000001);
    $display("overcurrent protection done");
    // mid-run reset; start-up times out, restarts, then latches on the second count
    up <= 1'b0;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, conv_prot_pkg::OFS_START, 32'h00000002);
    bus(1'b1, conv_prot_pkg::OFS_RESTART, 32'h00000002);
    repeat (400) @(posedge clk_i);
    bus(1'b0, conv_prot_pkg::OFS_FAULT, 32'h00000002);
    bus(1'b1, conv_prot_pkg::OFS_CTRL, 32'h00002207);
    repeat (600) @(posedge clk_i);
    bus(1'b0, conv_prot_pkg::OFS_STATUS, 32'h0010ff02);
    bus(1'b1, conv_prot_pkg::OFS_FAULT, 32'h00000002);
    bus(1'b0, conv_prot_pkg::OFS_FAULT, 32'h00000000);
    @(negedge clk_i);
    check("start latched", {31'h0, boost_run}, 32'h0);
    $display("start-up timeout done");
    // let the monitor take the last read before the verdict
    repeat (2) @(posedge clk_i);
    summarize();
  end
endmodule
